// >>> reset_seq_pkg.sv
// Constants, register map and types shared by the reset sequencer.
package reset_seq_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS       = 10;
    localparam int unsigned WARMUP_RC_TIME_NS   = 2000;
    localparam int unsigned WARMUP_XTAL_TIME_NS = 64000;
    // Least times, so the cycle counts round up.
    localparam int unsigned WARMUP_RC_CYCLES =
        (WARMUP_RC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WARMUP_XTAL_CYCLES =
        (WARMUP_XTAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WARM_CNT_W = 16;

    // ------------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------------
    localparam int unsigned PC_W = 13;
    localparam logic [PC_W-1:0] PROGRAM_START_ADDRESS = 13'h0000;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam int unsigned IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_PROGRAM_STATUS_FLAGS = 10'h086;
    localparam logic [IDX_W-1:0] IDX_EVENT_STATUS         = 10'h090;
    localparam logic [IDX_W-1:0] IDX_EVENT_CLEAR          = 10'h091;
    localparam logic [IDX_W-1:0] IDX_EVENT_ENABLE         = 10'h092;
    localparam logic [IDX_W-1:0] IDX_SEQ_STATE            = 10'h093;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned TIMEOUT_FLAG_BIT    = 7;
    localparam int unsigned POWER_DOWN_FLAG_BIT = 6;
    localparam logic [1:0] CAUSE_WATCHDOG = 2'h0;
    localparam logic [1:0] CAUSE_RESERVED = 2'h1;
    localparam logic [1:0] CAUSE_POWER    = 2'h2;
    localparam logic [1:0] CAUSE_EXT_PIN  = 2'h3;
    localparam logic [1:0] CAUSE_RESET    = CAUSE_POWER;

    localparam int unsigned EV_W     = 4;
    localparam int unsigned EV_WDT   = 0;
    localparam int unsigned EV_DROOP = 1;
    localparam int unsigned EV_PIN   = 2;
    localparam int unsigned EV_RUN   = 3;
    localparam logic [EV_W-1:0] EV_ENABLE_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Release sequence states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POWER_UP = 3'b000,
        ST_PIN_WAIT = 3'b001,
        ST_INIT     = 3'b010,
        ST_WARMUP   = 3'b011,
        ST_RUN      = 3'b100
    } seq_state_t;

    // True when a word address selects the given register index.
    function automatic logic reg_hit(input logic [31:0]      addr,
                                     input logic [IDX_W-1:0] idx);
        reg_hit = (addr[IDX_W+1:2] == idx) && (addr[1:0] == 2'h0);
    endfunction : reg_hit

endpackage : reset_seq_pkg

// >>> src_sync_if.sv
// Carrier between a reset source and its release synchroniser.
`timescale 1ns/100ps
interface src_sync_if;
    logic assert_async;
    logic held;

    modport sync (input assert_async, output held);
    modport user (output assert_async, input held);
endinterface : src_sync_if

// >>> src_release_sync.sv
// Reset source synchroniser: asserts at once, releases after two edges.
`timescale 1ns/100ps
module src_release_sync
    import reset_seq_pkg::*;
(
    input  wire logic  mclk_i,
    input  wire logic  clk_en_i,
    src_sync_if.sync   link
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    // A low shifts in one stage per enabled edge; only s2 is read.
    always_comb begin
        nxt_st = st_ff;
        if (clk_en_i) begin
            nxt_st.s1 = 1'b0;
            nxt_st.s2 = st_ff.s1;
        end
    end

    // The source sets both stages without waiting for a clock.
    always_ff @(posedge mclk_i or posedge link.assert_async) begin
        if (link.assert_async) begin
            st_ff <= '{s1: 1'b1, s2: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.held = st_ff.s2;

endmodule : src_release_sync

// >>> system_reset_sequencer.sv
// Reset source combiner, release sequencer and cause recorder.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
// Contract
// - Four sources put the device in reset
// - Reset holds registers, halts, clears counter
// - Execution starts at address zero afterwards
// - Cause code in status bits seven, six
// - Droop reports the power-on cause code
// - Wait for stable supply before proceeding
// - Stay in reset while pin not high
// - Wait oscillator warm-up before executing
// - Watchdog overflow resets, then normal operation
// - RC warm-up shorter than crystal warm-up
// - Pin is active low, level sensitive
// - Pin resets only when option selects it
module system_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned WARMUP_RC_CYC   = WARMUP_RC_CYCLES,
    parameter int unsigned WARMUP_XTAL_CYC = WARMUP_XTAL_CYCLES
)(
    input  wire logic            mclk_i,
    input  wire logic            rst_i,
    input  wire logic            clk_en_i,
    input  wire logic            ext_reset_n_i,
    input  wire logic            reset_pin_opt_i,
    input  wire logic            osc_crystal_i,
    input  wire logic            supply_stable_i,
    input  wire logic            supply_droop_detector_i,
    input  wire logic            wdt_overflow_i,
    input  wire logic            hsel_i,
    input  wire logic [31:0]     haddr_i,
    input  wire logic [1:0]      htrans_i,
    input  wire logic            hwrite_i,
    input  wire logic [2:0]      hsize_i,
    input  wire logic [31:0]     hwdata_i,
    input  wire logic            hready_i,
    output logic [31:0]          hrdata_o,
    output logic                 hreadyout_o,
    output logic                 hresp_o,
    output logic                 sys_reset_o,
    output logic                 pc_clear_o,
    output logic                 cpu_run_o,
    output logic [PC_W-1:0]      program_start_address_o,
    output logic                 irq_o
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (WARMUP_RC_CYC < 1 || WARMUP_RC_CYC >= WARMUP_XTAL_CYC ||
        WARMUP_XTAL_CYC >= (1 << WARM_CNT_W)) begin : g_bad_warmup
        $error("Warm-up counts must be 1 <= rc < crystal < 2**16.");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        seq_state_t             state;
        logic [WARM_CNT_W-1:0]  warm_cnt;
        logic                   xtal_sel;
        logic                   stable_s1;
        logic                   stable_s2;
        logic [1:0]             cause;
        logic [EV_W-1:0]        ev_status;
        logic [EV_W-1:0]        ev_enable;
        logic                   wr_pend;
        logic [IDX_W-1:0]       wr_idx;
        logic [31:0]            rdata;
    } top_state_t;

    localparam top_state_t TOP_RESET = '{
        state:     ST_POWER_UP,
        warm_cnt:  '0,
        xtal_sel:  1'b0,
        stable_s1: 1'b0,
        stable_s2: 1'b0,
        cause:     CAUSE_RESET,
        ev_status: '0,
        ev_enable: EV_ENABLE_RESET,
        wr_pend:   1'b0,
        wr_idx:    '0,
        rdata:     '0
    };

    top_state_t st_ff;
    top_state_t nxt_st;

    src_sync_if droop_link();
    src_sync_if pin_link();

    logic                  droop_held;
    logic                  pin_held;
    logic                  addr_phase;
    logic [WARM_CNT_W-1:0] warm_last;
    logic [EV_W-1:0]       ev_clear;
    logic [EV_W-1:0]       ev_set;
    logic [31:0]           rd_value;

    // ------------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------------
    // Droop and power-on share one path so both report the same cause.
    assign droop_link.assert_async = supply_droop_detector_i | rst_i;
    // The pin counts only when the option selects it; low resets.
    assign pin_link.assert_async =
        reset_pin_opt_i & ~ext_reset_n_i;

    src_release_sync u_droop_sync (
        .mclk_i   (mclk_i),
        .clk_en_i (clk_en_i),
        .link     (droop_link)
    );

    // Release of the pin is seen only after two clean edges.
    src_release_sync u_pin_sync (
        .mclk_i   (mclk_i),
        .clk_en_i (clk_en_i),
        .link     (pin_link)
    );

    assign droop_held = droop_link.held;
    assign pin_held   = pin_link.held;

    // ------------------------------------------------------------------
    // Bus decode and read mux
    // ------------------------------------------------------------------
    assign addr_phase = hsel_i & htrans_i[1] & hready_i;

    // Register contents as seen by a read; unmapped words read zero.
    always_comb begin
        rd_value = 32'h0000_0000;
        if (reg_hit(haddr_i, IDX_PROGRAM_STATUS_FLAGS)) begin
            rd_value[TIMEOUT_FLAG_BIT]    = st_ff.cause[1];
            rd_value[POWER_DOWN_FLAG_BIT] = st_ff.cause[0];
        end else if (reg_hit(haddr_i, IDX_EVENT_STATUS)) begin
            rd_value[EV_W-1:0] = st_ff.ev_status;
        end else if (reg_hit(haddr_i, IDX_EVENT_ENABLE)) begin
            rd_value[EV_W-1:0] = st_ff.ev_enable;
        end else if (reg_hit(haddr_i, IDX_SEQ_STATE)) begin
            rd_value[2:0] = st_ff.state;
        end
    end

    // The oscillator type picks the warm-up length.
    assign warm_last = st_ff.xtal_sel ?
        WARM_CNT_W'(WARMUP_XTAL_CYC - 1) :
        WARM_CNT_W'(WARMUP_RC_CYC - 1);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Bus writes land first so that hardware events override them.
    always_comb begin
        nxt_st   = st_ff;
        ev_clear = '0;
        ev_set   = '0;
        if (clk_en_i) begin
            nxt_st.stable_s1 = supply_stable_i;
            nxt_st.stable_s2 = st_ff.stable_s1;

            // Data phase of a write captured in the previous cycle.
            nxt_st.wr_pend = 1'b0;
            if (st_ff.wr_pend) begin
                case (st_ff.wr_idx)
                    IDX_PROGRAM_STATUS_FLAGS: begin
                        nxt_st.cause = {hwdata_i[TIMEOUT_FLAG_BIT],
                                        hwdata_i[POWER_DOWN_FLAG_BIT]};
                    end
                    IDX_EVENT_CLEAR: begin
                        ev_clear = hwdata_i[EV_W-1:0];
                    end
                    IDX_EVENT_ENABLE: begin
                        nxt_st.ev_enable = hwdata_i[EV_W-1:0];
                    end
                    default: begin
                        ev_clear = '0;
                    end
                endcase
            end

            // Address phase: reads fetch now, writes wait one cycle.
            nxt_st.rdata = 32'h0000_0000;
            if (addr_phase) begin
                nxt_st.wr_pend = hwrite_i;
                nxt_st.wr_idx  = haddr_i[IDX_W+1:2];
                if (!hwrite_i) begin
                    nxt_st.rdata = rd_value;
                end
            end

            // Reset sources, strongest first, then the release steps.
            if (droop_held) begin
                nxt_st.state    = ST_POWER_UP;
                nxt_st.cause    = CAUSE_POWER;
                ev_set[EV_DROOP] = 1'b1;
            end else if (pin_held) begin
                nxt_st.state    = (st_ff.state == ST_POWER_UP) ?
                                  ST_POWER_UP : ST_PIN_WAIT;
                nxt_st.cause    = CAUSE_EXT_PIN;
                ev_set[EV_PIN]  = 1'b1;
            end else if (wdt_overflow_i) begin
                nxt_st.state    = (st_ff.state == ST_POWER_UP) ?
                                  ST_POWER_UP : ST_INIT;
                nxt_st.cause    = CAUSE_WATCHDOG;
                ev_set[EV_WDT]  = 1'b1;
            end else begin
                case (st_ff.state)
                    ST_POWER_UP: begin
                        if (st_ff.stable_s2) begin
                            nxt_st.state = ST_PIN_WAIT;
                        end
                    end
                    ST_PIN_WAIT: begin
                        // Only reached here with the pin released high or its option off.
                        nxt_st.state = ST_INIT;
                    end
                    ST_INIT: begin
                        nxt_st.state    = ST_WARMUP;
                        nxt_st.warm_cnt = '0;
                        nxt_st.xtal_sel = osc_crystal_i;
                    end
                    ST_WARMUP: begin
                        if (st_ff.warm_cnt == warm_last) begin
                            nxt_st.state  = ST_RUN;
                            ev_set[EV_RUN] = 1'b1;
                        end else begin
                            nxt_st.warm_cnt = st_ff.warm_cnt + 1'b1;
                        end
                    end
                    ST_RUN: begin
                        nxt_st.state = ST_RUN;
                    end
                    default: begin
                        nxt_st.state = ST_POWER_UP;
                    end
                endcase
            end

            // Sticky events: a set in the clearing cycle is kept.
            nxt_st.ev_status = (st_ff.ev_status & ~ev_clear) | ev_set;
        end
    end

    // Register the whole state; only power-on clears it.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= TOP_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Any held source asserts reset at once, without a clock edge.
    assign sys_reset_o = droop_held | pin_held |
                         (st_ff.state != ST_RUN);
    assign pc_clear_o  = sys_reset_o;
    assign cpu_run_o   = ~sys_reset_o;
    assign program_start_address_o = PROGRAM_START_ADDRESS;
    assign irq_o       = |(st_ff.ev_status & st_ff.ev_enable);
    assign hrdata_o    = st_ff.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    logic quiet;
    assign quiet = clk_en_i & ~droop_held & ~pin_held & ~wdt_overflow_i;

    property p_src_resets;
        (reset_pin_opt_i && !ext_reset_n_i) || (wdt_overflow_i && clk_en_i)
            |-> (sys_reset_o or (##1 sys_reset_o));
    endproperty
    a_src_resets: assert property (p_src_resets)
        else $error("Reset source did not assert reset.");

    property p_halt;
        sys_reset_o |-> !cpu_run_o && pc_clear_o &&
            program_start_address_o == 13'h0000;
    endproperty
    a_halt: assert property (p_halt)
        else $error("Execution not halted during reset.");

    property p_wdt_cause;
        st_ff.state == ST_RUN && clk_en_i && wdt_overflow_i &&
            !droop_held && !pin_held
            |=> st_ff.cause == 2'h0 && st_ff.state == ST_INIT;
    endproperty
    a_wdt_cause: assert property (p_wdt_cause)
        else $error("Watchdog reset cause not recorded.");

    property p_droop_cause;
        clk_en_i && droop_held |=> st_ff.cause == 2'h2 &&
            st_ff.state == ST_POWER_UP;
    endproperty
    a_droop_cause: assert property (p_droop_cause)
        else $error("Droop reset not reported as power cause.");

    property p_pin_cause;
        clk_en_i && pin_held && !droop_held |=> st_ff.cause == 2'h3;
    endproperty
    a_pin_cause: assert property (p_pin_cause)
        else $error("Pin reset cause not recorded.");

    property p_wait_stable;
        st_ff.state == ST_POWER_UP && !st_ff.stable_s2
            |=> st_ff.state == ST_POWER_UP;
    endproperty
    a_wait_stable: assert property (p_wait_stable)
        else $error("Left power-up before supply stable.");

    property p_pin_hold;
        pin_held |-> !cpu_run_o ##1 (st_ff.state == ST_PIN_WAIT ||
            st_ff.state == ST_POWER_UP || !clk_en_i);
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("Left reset while pin held low.");

    property p_warm_hold;
        st_ff.state == ST_WARMUP && st_ff.warm_cnt != warm_last && quiet
            |=> st_ff.state == ST_WARMUP && !cpu_run_o;
    endproperty
    a_warm_hold: assert property (p_warm_hold)
        else $error("Execution began before warm-up ended.");

    property p_warm_done;
        st_ff.state == ST_WARMUP && st_ff.warm_cnt == warm_last && quiet
            |=> cpu_run_o;
    endproperty
    a_warm_done: assert property (p_warm_done)
        else $error("Execution did not start after warm-up.");

    property p_rc_short;
        $rose(cpu_run_o) && !st_ff.xtal_sel |->
            $past(st_ff.warm_cnt) == WARM_CNT_W'(WARMUP_RC_CYC - 1);
    endproperty
    a_rc_short: assert property (p_rc_short)
        else $error("RC warm-up length wrong.");

    property p_pin_option;
        !reset_pin_opt_i && !droop_held && $past(!pin_held)
            |-> !pin_held;
    endproperty
    a_pin_option: assert property (p_pin_option)
        else $error("Pin reset acted with option off.");

    property p_sticky;
        st_ff.ev_status[EV_WDT] && !st_ff.wr_pend
            |=> st_ff.ev_status[EV_WDT];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Sticky event lost without clear.");

    c_run: cover property ($rose(cpu_run_o));
    c_wdt: cover property (st_ff.state == ST_RUN ##1
                           st_ff.cause == 2'h0);
    c_pin: cover property (pin_held ##1 !pin_held);
    c_xtal: cover property ($rose(cpu_run_o) && st_ff.xtal_sel);

endmodule : system_reset_sequencer

// >>> supply_pin_model.sv
// Behavioural external reset circuit and supply voltage monitor.
`timescale 1ns/100ps
module supply_pin_model #(
    parameter int unsigned STABLE_DLY = 30
)(
    input  wire logic mclk_i,
    input  wire logic por_i,
    input  wire logic droop_i,
    input  wire logic pin_low_i,
    output logic      ext_reset_n_o,
    output logic      supply_stable_o,
    output logic      supply_droop_detector_o
);
    int unsigned ramp_cnt;

    // The pin idles high and goes low only while a reset is requested.
    assign ext_reset_n_o = !pin_low_i;
    // The detector follows a dip at once, with no clock involved.
    assign supply_droop_detector_o = droop_i;

    // The supply ramps again after every dip, so stable comes late.
    always_ff @(posedge mclk_i or posedge por_i or posedge droop_i) begin
        if (por_i || droop_i) begin
            ramp_cnt <= 0;
        end else if (ramp_cnt < STABLE_DLY) begin
            ramp_cnt <= ramp_cnt + 1;
        end
    end
    assign supply_stable_o = (ramp_cnt >= STABLE_DLY);
endmodule : supply_pin_model

// >>> tb_system_reset_sequencer.sv
// Self-checking bench for the system reset sequencer.
`timescale 1ns/100ps
module tb_system_reset_sequencer;
    import reset_seq_pkg::*;

    localparam int unsigned RC_N = 3;
    localparam int unsigned XT_N = 8;

    logic            mclk_i, rst_i, osc, wdt, pin_opt, pin_low, droop;
    logic            ext_n, stable, droop_det, hsel, hwrite, clk_en;
    logic [1:0]      htrans;
    logic [31:0]     haddr, hwdata, hrdata_o, rd;
    logic            hreadyout_o, hresp_o, sys_reset_o, pc_clear_o;
    logic            cpu_run_o, irq_o;
    logic [PC_W-1:0] start_addr;
    int              err_count, num_checks, n_rc, n_xt;

    supply_pin_model #(.STABLE_DLY(30)) PARTNER (
        .mclk_i(mclk_i), .por_i(rst_i), .droop_i(droop),
        .pin_low_i(pin_low), .ext_reset_n_o(ext_n),
        .supply_stable_o(stable), .supply_droop_detector_o(droop_det));

    system_reset_sequencer #(.WARMUP_RC_CYC(RC_N), .WARMUP_XTAL_CYC(XT_N))
    DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .clk_en_i(clk_en),
        .ext_reset_n_i(ext_n), .reset_pin_opt_i(pin_opt),
        .osc_crystal_i(osc), .supply_stable_i(stable),
        .supply_droop_detector_i(droop_det), .wdt_overflow_i(wdt),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .sys_reset_o(sys_reset_o), .pc_clear_o(pc_clear_o),
        .cpu_run_o(cpu_run_o), .program_start_address_o(start_addr),
        .irq_o(irq_o));

    // ------------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------------
    // The clock toggles every 5 ns, half of its 10 ns period.
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // A hang is cut short long after the tests should have ended.
    initial begin
        #400000;
        err_count++;
        end_sim();
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // ------------------------------------------------------------------
    // Bus and sequence tasks
    // ------------------------------------------------------------------
    // Waits for an edge with hready high, under a bounded count.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge mclk_i);
        while (hreadyout_o !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk_i);
        end
        chk_bit(hreadyout_o, 1'b1);
    endtask : wait_ready

    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic wr, input logic [IDX_W-1:0] idx,
                       input logic [31:0] wd);
        @(posedge mclk_i);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {20'h0, idx, 2'h0};
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata_o;
        chk_bit(hresp_o, 1'b0);
    endtask : bus

    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        chk_word(rd, e);
    endtask : rd_chk

    // Lets the edge after a write land before outputs are looked at.
    task automatic settle();
        @(posedge mclk_i);
        #1;
    endtask : settle

    task automatic wait_run();
        int n;
        n = 0;
        while (cpu_run_o !== 1'b1 && n < 300) begin
            n++;
            @(posedge mclk_i);
        end
        chk_bit(cpu_run_o, 1'b1);
    endtask : wait_run

    // Pulses the watchdog and counts the edges spent in reset.
    task automatic wdt_reset(output int c);
        c = 0;
        wdt <= 1'b1;
        @(posedge mclk_i);
        wdt <= 1'b0;
        #1;
        chk_bit(sys_reset_o, 1'b1);
        chk_bit(pc_clear_o, 1'b1);
        chk_bit(cpu_run_o, 1'b0);
        while (sys_reset_o !== 1'b0 && c < 300) begin
            @(posedge mclk_i);
            #1;
            c++;
        end
    endtask : wdt_reset

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    // Power-on, then watchdog, interrupt, pin and droop resets in turn.
    initial begin
        {err_count, num_checks} = 0;
        {rst_i, pin_opt, clk_en} = 3'b111;
        {osc, wdt, pin_low, droop, hsel, hwrite} = 6'h00;
        {htrans, haddr, hwdata} = '0;
        repeat (8) @(posedge mclk_i);
        chk_bit(pc_clear_o, 1'b1);
        rst_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        rd_chk(IDX_SEQ_STATE, 32'h0);
        chk_bit(sys_reset_o, 1'b1);
        wait_run();
        chk_word({19'h0, start_addr}, 32'h0);
        rd_chk(IDX_PROGRAM_STATUS_FLAGS, {24'h0, CAUSE_POWER, 6'h0});
        rd_chk(IDX_EVENT_STATUS, 32'ha);
        rd_chk(IDX_EVENT_ENABLE, 32'h0);
        rd_chk(IDX_SEQ_STATE, 32'h4);
        rd_chk(10'h3ff, 32'h0);
        bus(1'b1, IDX_SEQ_STATE, 32'h0);
        rd_chk(IDX_SEQ_STATE, 32'h4);
        bus(1'b1, IDX_PROGRAM_STATUS_FLAGS, 32'hff);
        rd_chk(IDX_PROGRAM_STATUS_FLAGS, 32'hc0);
        wdt_reset(n_rc);
        wait_run();
        rd_chk(IDX_PROGRAM_STATUS_FLAGS, {24'h0, CAUSE_WATCHDOG, 6'h0});
        osc <= 1'b1;
        wdt_reset(n_xt);
        wait_run();
        chk_word(32'(n_xt - n_rc), 32'(XT_N - RC_N));
        chk_bit(n_rc >= RC_N, 1'b1);
        // Interrupt: raised by a watchdog event, masked, then cleared.
        bus(1'b1, IDX_EVENT_CLEAR, 32'hf);
        rd_chk(IDX_EVENT_STATUS, 32'h0);
        bus(1'b1, IDX_EVENT_ENABLE, 32'h1 << EV_WDT);
        wdt_reset(n_rc);
        wait_run();
        chk_bit(irq_o, 1'b1);
        bus(1'b1, IDX_EVENT_ENABLE, 32'h0);
        settle();
        chk_bit(irq_o, 1'b0);
        bus(1'b1, IDX_EVENT_ENABLE, 32'h1 << EV_WDT);
        settle();
        chk_bit(irq_o, 1'b1);
        bus(1'b1, IDX_EVENT_CLEAR, 32'h1 << EV_WDT);
        settle();
        chk_bit(irq_o, 1'b0);
        // The pin is ignored unless the option selects it.
        @(posedge mclk_i);
        pin_opt <= 1'b0;
        pin_low <= 1'b1;
        repeat (10) @(posedge mclk_i);
        #1;
        chk_bit(sys_reset_o, 1'b0);
        @(posedge mclk_i);
        pin_low <= 1'b0;
        @(posedge mclk_i);
        pin_opt <= 1'b1;
        @(posedge mclk_i);
        pin_low <= 1'b1;
        #1;
        chk_bit(sys_reset_o, 1'b1);
        repeat (20) @(posedge mclk_i);
        #1;
        chk_bit(sys_reset_o, 1'b1);
        @(posedge mclk_i);
        pin_low <= 1'b0;
        wait_run();
        rd_chk(IDX_PROGRAM_STATUS_FLAGS, {24'h0, CAUSE_EXT_PIN, 6'h0});
        rd_chk(IDX_EVENT_STATUS, 32'hc);
        // A low clock enable freezes the sequencer, so a watchdog is lost.
        clk_en <= 1'b0;
        wdt    <= 1'b1;
        @(posedge mclk_i);
        {clk_en, wdt} <= 2'b10;
        #1;
        chk_bit(sys_reset_o, 1'b0);
        @(posedge mclk_i);
        // A supply dip resets without a clock edge and reports power-on.
        droop <= 1'b1;
        #1;
        chk_bit(sys_reset_o, 1'b1);
        @(posedge mclk_i);
        droop <= 1'b0;
        wait_run();
        rd_chk(IDX_PROGRAM_STATUS_FLAGS, {24'h0, CAUSE_POWER, 6'h0});
        end_sim();
    end
endmodule : tb_system_reset_sequencer
